// ===== core/timer_map.svh
// Timer constants: dividers, count limits and reset values
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Timer clock divider in timer operation
`define TMR_DIV_TIMER 6
// Fast divider for clock-output and baud operation
`define TMR_DIV_FAST 2
// Top of the 16-bit count
`define TMR_COUNT_MAX 16'hffff
// Reset values of count and reload pair
`define TMR_COUNT_RST 16'h0000
`define TMR_RELOAD_RST 16'h0000
// Width of one count byte
`define TMR_BYTE_W 8

`endif

// ===== core/timer_pkg.sv
// Types shared by the up/down reload timer
package timer_pkg;

  // Control and mode bits held by software
  typedef struct packed {
    logic receive_clock_select;
    logic transmit_clock_select;
    logic run_control_bit;
    logic counter_select_bit;
    logic updown_enable_bit;
    logic clock_output_enable;
  } ctrl_t;

  // One software write of a 16-bit pair
  typedef struct packed {
    logic en;
    logic [15:0] data;
  } wr_t;

endpackage : timer_pkg

// ===== core/rate_divider.sv
// Divider giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
module rate_divider #(
  parameter int unsigned DIV = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Run enable; clearing it restarts the division
  input wire logic en,
  // Enable pulse
  output logic tick
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  // Count to DIV-1, then pulse and wrap
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!en) begin
      next_cnt = '0;
    end else if (cnt == W'(DIV - 1)) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : rate_divider

// ===== core/count_edge_detect.sv
// Falling-edge detector for the external count input
`timescale 1ns/1ps
module count_edge_detect (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin level, already synchronous
  input wire logic pin,
  // One-cycle pulse per high-to-low transition
  output logic fall
);
  logic prev;
  logic next_fall;

  // Low now, high last cycle
  always_comb begin
    next_fall = prev & ~pin;
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b1; // Idle pin is high; no false edge after reset
      fall <= 1'b0;
    end else begin
      prev <= pin;
      fall <= next_fall;
    end
  end

endmodule : count_edge_detect

// ===== core/updown_reload_timer.sv
// 16-bit up/down auto-reload timer with programmable clock output
//
// Summary of operation
// (R1) Count is low byte cascaded into high byte
// (R2) Select bit picks clock/6 or pin edges
// (R3) Counting frozen while run bit clear
// (R4) Up/down enable lets direction pin steer
// (R5) Up: wrap at FFFFh, flag, irq, reload
// (R6) Down: at reload value, flag, load FFFFh
// (R7) Up/down mode: external flag toggles on wrap, no irq
// (R8) Clock-out: count at clock/2, reload, toggle
// (R9) Clock-out overflows raise no interrupt
// (R10) Output rate is clock/(4*(65536-reload))
// (R11) Generated clock drives external count pin
// (R12) Software sets up clock-out in order
// (R13) Baud and clock-out share reload pair
// (R14) Flag set by hardware, software clears
// (R15) Serial select bits route overflow to baud
// (R16) Without up/down enable, count up only
`timescale 1ns/1ps
`include "timer_map.svh"
module updown_reload_timer #(
  parameter int unsigned TIMER_DIV = `TMR_DIV_TIMER,
  parameter int unsigned FAST_DIV = `TMR_DIV_FAST
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control and mode bits
  input wire timer_pkg::ctrl_t ctrl,
  // Software writes of count and reload pair
  input wire timer_pkg::wr_t count_wr,
  input wire timer_pkg::wr_t reload_wr,
  // Software flag clears, one-cycle pulses
  input wire logic overflow_flag_clr,
  input wire logic external_flag_clr,
  // Pins
  input wire logic external_count_pin_in,
  input wire logic direction_input_pin,
  output logic external_count_pin_out,
  output logic external_count_pin_oe,
  // Count and reload readback
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic [7:0] reload_low_byte,
  output logic [7:0] reload_high_byte,
  // Flags and events
  output logic overflow_flag,
  output logic external_flag,
  output logic irq_request,
  output logic serial_baud_tick
);

  logic div_timer_tick;
  logic div_fast_tick;
  logic pin_fall;
  logic baud_mode;
  logic fast_mode;
  logic count_down;
  logic step;
  logic wrap;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic next_overflow_flag;
  logic next_external_flag;
  logic next_irq_request;
  logic next_baud_tick;
  logic next_pin_out;
  logic next_pin_oe;

  // Low byte increments; high byte takes its carry
  function automatic logic [15:0] bump_up(input logic [15:0] v);
    logic [8:0] lo;
    logic [7:0] hi;
    lo = {1'b0, v[7:0]} + 9'h001;
    hi = v[15:8] + {7'h00, lo[8]};
    return {hi, lo[7:0]};
  endfunction : bump_up

  assign count = {count_high_byte, count_low_byte};
  assign reload = {reload_high_byte, reload_low_byte};

  // Timer operation rate, runs only while enabled
  rate_divider #(
    .DIV(TIMER_DIV)
  ) u_div_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .en(ctrl.run_control_bit),
    .tick(div_timer_tick)
  );

  // Clock-out and baud rate at half the clock
  rate_divider #(
    .DIV(FAST_DIV)
  ) u_div_fast (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .en(ctrl.run_control_bit),
    .tick(div_fast_tick)
  );

  // Event counting on external pin transitions
  count_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(external_count_pin_in),
    .fall(pin_fall)
  );

  // Mode decode; the pin is ignored in clock-out since we drive it
  always_comb begin
    baud_mode = ctrl.receive_clock_select | ctrl.transmit_clock_select; // R15
    fast_mode = ctrl.clock_output_enable | baud_mode; // R13
    count_down = ctrl.updown_enable_bit & ~direction_input_pin & ~fast_mode;
    step = 1'b0;
    if (ctrl.run_control_bit) begin // R3
      if (fast_mode) begin
        step = div_fast_tick; // R8
      end else if (ctrl.counter_select_bit) begin
        step = pin_fall; // R2
      end else begin
        step = div_timer_tick; // R2
      end
    end
  end

  // Count and reload next values; a software write beats a step
  always_comb begin
    next_count = count;
    next_reload = reload;
    wrap = 1'b0;
    if (reload_wr.en) begin
      next_reload = reload_wr.data;
    end
    if (count_wr.en) begin
      next_count = count_wr.data;
    end else if (step) begin
      if (count_down) begin // R4
        if (count == reload) begin // R6
          next_count = `TMR_COUNT_MAX;
          wrap = 1'b1;
        end else begin
          next_count = count - 16'h0001;
        end
      end else if (count == `TMR_COUNT_MAX) begin // R5 R16
        next_count = reload; // R13
        wrap = 1'b1;
      end else begin
        next_count = bump_up(count); // R1
      end
    end
  end

  // Flags: a hardware set or toggle wins over a clear in the same cycle
  always_comb begin
    next_overflow_flag = overflow_flag & ~overflow_flag_clr; // R14
    if (wrap && !baud_mode) begin
      next_overflow_flag = 1'b1; // R5 R14
    end
    next_external_flag = external_flag & ~external_flag_clr;
    if (wrap && ctrl.updown_enable_bit && !fast_mode) begin
      next_external_flag = ~external_flag; // R7
    end
    // Only the overflow flag requests service
    next_irq_request = next_overflow_flag & ~ctrl.clock_output_enable; // R9
    next_baud_tick = wrap & baud_mode; // R15
  end

  // Clock output: toggle at each wrap, so period is 4*(65536-reload)
  always_comb begin
    next_pin_oe = ctrl.clock_output_enable; // R11
    next_pin_out = 1'b0;
    if (ctrl.clock_output_enable) begin
      next_pin_out = wrap ? ~external_count_pin_out : external_count_pin_out; // R10
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte <= 8'(`TMR_COUNT_RST);
      count_high_byte <= 8'(`TMR_COUNT_RST >> 8);
      reload_low_byte <= 8'(`TMR_RELOAD_RST);
      reload_high_byte <= 8'(`TMR_RELOAD_RST >> 8);
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
      irq_request <= 1'b0;
      serial_baud_tick <= 1'b0;
      external_count_pin_out <= 1'b0;
      external_count_pin_oe <= 1'b0;
    end else begin
      count_low_byte <= next_count[7:0];
      count_high_byte <= next_count[15:8];
      reload_low_byte <= next_reload[7:0];
      reload_high_byte <= next_reload[15:8];
      overflow_flag <= next_overflow_flag;
      external_flag <= next_external_flag;
      irq_request <= next_irq_request;
      serial_baud_tick <= next_baud_tick;
      external_count_pin_out <= next_pin_out;
      external_count_pin_oe <= next_pin_oe;
    end
  end

  // Checks on the timer's own behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Stopped timer holds its count
  a_freeze_when_stopped: assert property ( // R3
    !ctrl.run_control_bit && !count_wr.en |=> $stable(count))
    else $error("count moved while stopped");

  // Ordinary up step carries low into high
  a_up_step_carry: assert property ( // R1
    step && !count_down && !count_wr.en && count != `TMR_COUNT_MAX
    |=> count == $past(count) + 16'h0001)
    else $error("up step wrong");

  // Up wrap loads reload pair and sets flag
  a_up_wrap_reload: assert property ( // R5
    step && !count_down && !count_wr.en && !baud_mode
    && count == `TMR_COUNT_MAX
    |=> count == $past(reload) && overflow_flag)
    else $error("up wrap did not reload");

  // Down underflow at reload value loads top
  a_down_underflow: assert property ( // R6
    step && count_down && !count_wr.en && count == reload
    |=> count == `TMR_COUNT_MAX)
    else $error("underflow did not load top");

  // External flag flips on every up/down wrap
  a_ext_flag_toggle: assert property ( // R7
    wrap && ctrl.updown_enable_bit && !fast_mode
    |=> external_flag != $past(external_flag))
    else $error("external flag did not toggle");

  // No interrupt while clock output runs
  a_clkout_no_irq: assert property ( // R9
    $past(ctrl.clock_output_enable) |-> !irq_request)
    else $error("interrupt in clock-out mode");

  // Output pin flips at each clock-out wrap
  a_clkout_toggle: assert property ( // R8
    wrap && ctrl.clock_output_enable
    |=> external_count_pin_out != $past(external_count_pin_out))
    else $error("clock output did not toggle");

  // Pin is driven while clock output stays on
  a_pin_drive: assert property ( // R11
    ctrl.clock_output_enable ##1 ctrl.clock_output_enable
    |-> external_count_pin_oe)
    else $error("pin not driven in clock-out");

  // Serial use never sets the flag
  a_baud_no_flag: assert property ( // R14
    wrap && baud_mode && !overflow_flag |=> !overflow_flag)
    else $error("flag set in baud mode");

  // Timer rate pulses are six cycles apart
  a_timer_rate: assert property ( // R2
    div_timer_tick |=> !div_timer_tick [*5])
    else $error("timer divider rate wrong");

  // Fast rate pulses are two cycles apart
  a_fast_rate: assert property ( // R8
    div_fast_tick |=> !div_fast_tick)
    else $error("fast divider rate wrong");

  // Software count write lands next cycle
  a_count_write: assert property ( // R1
    count_wr.en |=> count == $past(count_wr.data))
    else $error("count write lost");

  // Software reload write lands next cycle
  a_reload_write: assert property ( // R13
    reload_wr.en |=> reload == $past(reload_wr.data))
    else $error("reload write lost");

  // Ordinary down step subtracts one
  a_down_step: assert property ( // R6
    step && count_down && !count_wr.en && count != reload
    |=> count == $past(count) - 16'h0001)
    else $error("down step wrong");

  // Timer wrap outside clock-out and baud requests service
  a_wrap_raises_irq: assert property ( // R5
    wrap && !baud_mode && !ctrl.clock_output_enable |=> irq_request)
    else $error("wrap gave no interrupt");

  // Pin is released and low once clock output is off
  a_pin_released: assert property ( // R11
    !ctrl.clock_output_enable
    |=> !external_count_pin_oe && !external_count_pin_out)
    else $error("pin still driven");

  // Each baud-mode wrap gives one serial tick
  a_baud_tick_out: assert property ( // R15
    wrap && baud_mode |=> serial_baud_tick)
    else $error("baud wrap gave no tick");

  // Clock-out and baud wraps leave the external flag alone
  a_fast_no_ext: assert property ( // R7
    wrap && fast_mode && !external_flag_clr |=> $stable(external_flag))
    else $error("external flag moved in fast mode");

  // Main scenarios
  c_up_wrap: cover property (wrap && !count_down && !fast_mode);
  c_down_wrap: cover property (wrap && count_down);
  c_clkout_edge: cover property (wrap && ctrl.clock_output_enable);
  c_baud_tick: cover property (serial_baud_tick);

endmodule : updown_reload_timer

// ===== bench/pin_partner.sv
// Pin-side model: external count source and direction level
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input wire logic clk_sys,
  // Bench requests
  input wire logic pulse_req,
  input wire logic dir_up,
  // Device drive of the count pin
  input wire logic dev_out,
  input wire logic dev_oe,
  // Pin levels
  output logic pin,
  output logic dir_pin
);
  logic [1:0] low_cnt = 2'h0;

  // Three-cycle low pulse, only while the device leaves the pin alone
  always @(posedge clk_sys) begin
    if (pulse_req && !dev_oe) low_cnt <= 2'h3;
    else if (low_cnt != 2'h0) low_cnt <= low_cnt - 2'h1;
  end

  // Device wins the pin while driving; pull-up holds it high otherwise
  assign pin = dev_oe ? dev_out : (low_cnt == 2'h0);
  assign dir_pin = dir_up;
endmodule : pin_partner

// ===== bench/tb.sv
// Self-checking bench for the up/down reload timer
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, oclr, eclr, preq, dir_up, pin, dir_pin;
  logic pout, poe, ovf, ext, irq, baud;
  logic [7:0] cl, ch, rl, rh;
  timer_pkg::ctrl_t ctrl;
  timer_pkg::wr_t cwr, rwr;
  int n_mismatch = 0;
  int compares = 0;
  int ticks = 0;
  int n;
  wire [15:0] cnt = {ch, cl};

  updown_reload_timer i_updown_reload_timer (.clk_sys(clk_sys),
    .rst_n(rst_n), .ctrl(ctrl), .count_wr(cwr), .reload_wr(rwr),
    .overflow_flag_clr(oclr), .external_flag_clr(eclr),
    .external_count_pin_in(pin), .direction_input_pin(dir_pin),
    .external_count_pin_out(pout), .external_count_pin_oe(poe),
    .count_low_byte(cl), .count_high_byte(ch), .reload_low_byte(rl),
    .reload_high_byte(rh), .overflow_flag(ovf), .external_flag(ext),
    .irq_request(irq), .serial_baud_tick(baud));

  pin_partner i_pin_partner (.clk_sys(clk_sys), .pulse_req(preq),
    .dir_up(dir_up), .dev_out(pout), .dev_oe(poe), .pin(pin),
    .dir_pin(dir_pin));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic conclude;
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  // One-cycle write pulses of a 16-bit pair
  task automatic wr(input bit rel, input logic [15:0] d);
    @(posedge clk_sys);
    if (rel) rwr <= '{1'b1, d};
    else cwr <= '{1'b1, d};
    @(posedge clk_sys);
    rwr.en <= 1'b0;
    cwr.en <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic set_ctrl(input logic [5:0] v);
    @(posedge clk_sys);
    ctrl <= timer_pkg::ctrl_t'(v);
  endtask : set_ctrl

  task automatic clr_flags;
    @(posedge clk_sys);
    oclr <= 1'b1;
    eclr <= 1'b1;
    @(posedge clk_sys);
    oclr <= 1'b0;
    eclr <= 1'b0;
    cyc(1);
  endtask : clr_flags

  // Cycles until the count next moves, sampled at settled points
  task automatic step(output int k);
    logic [15:0] old;
    old = cnt;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (cnt === old && k < 60);
  endtask : step

  // Cycles between two rising edges of the count pin or the baud tick
  task automatic gap(input bit sel, output int k);
    int w;
    w = 0;
    k = 0;
    // Align on a rising edge first, then count a whole period
    do begin
      @(negedge clk_sys);
      w++;
    end while ((sel ? baud : pin) === 1'b1 && w < 60);
    while ((sel ? baud : pin) !== 1'b1 && w < 60) begin
      @(negedge clk_sys);
      w++;
    end
    do begin
      @(negedge clk_sys);
      k++;
    end while ((sel ? baud : pin) === 1'b1 && k < 60);
    while ((sel ? baud : pin) !== 1'b1 && k < 60) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : gap

  // Timer mode counting up, wrap, flag clear and freeze
  task automatic t_timer_up;
    wr(1, 16'h5a00);
    wr(0, 16'hfffe);
    set_ctrl(6'h08);
    step(n);
    chk("count", cnt, 16'hffff);
    step(n);
    chk("step gap", n, 6);
    chk("count", cnt, 16'h5a00);
    chk("ovf", ovf, 1'b1);
    chk("irq", irq, 1'b1);
    chk("ext", ext, 1'b0);
    clr_flags();
    chk("ovf", ovf, 1'b0);
    set_ctrl(6'h00);
    cyc(20);
    chk("frozen", cnt, 16'h5a00);
  endtask : t_timer_up

  // Up/down mode: down to the reload value, then up through FFFFh
  task automatic t_updown;
    wr(1, 16'h1234);
    wr(0, 16'h1235);
    set_ctrl(6'h0a);
    step(n);
    chk("count", cnt, 16'h1234);
    step(n);
    chk("count", cnt, 16'hffff);
    chk("ovf", ovf, 1'b1);
    chk("ext", ext, 1'b1);
    @(posedge clk_sys);
    dir_up <= 1'b1;
    step(n);
    chk("count", cnt, 16'h1234);
    chk("ext", ext, 1'b0);
    set_ctrl(6'h00);
    clr_flags();
  endtask : t_updown

  // Counter mode driven by pin edges only
  task automatic t_counter;
    wr(0, 16'h0010);
    set_ctrl(6'h0c);
    cyc(20);
    chk("no edge", cnt, 16'h0010);
    @(posedge clk_sys);
    preq <= 1'b1;
    @(posedge clk_sys);
    preq <= 1'b0;
    step(n);
    chk("count", cnt, 16'h0011);
    set_ctrl(6'h00);
  endtask : t_counter

  // Clock output: setup order, pin drive, period, no interrupt
  task automatic t_clock_out;
    set_ctrl(6'h01);
    wr(1, 16'hfffe);
    wr(0, 16'hfffe);
    set_ctrl(6'h09);
    cyc(4);
    chk("oe", poe, 1'b1);
    gap(0, n);
    chk("period", n, 8);
    chk("irq", irq, 1'b0);
    chk("reload", {rh, rl}, 16'hfffe);
    set_ctrl(6'h00);
    cyc(3);
    chk("out", pout, 1'b0);
    clr_flags();
  endtask : t_clock_out

  // Baud source sharing the reload pair; flag stays clear
  task automatic t_baud;
    set_ctrl(6'h18);
    gap(1, n);
    chk("baud gap", n, 4);
    chk("ovf", ovf, 1'b0);
    set_ctrl(6'h28);
    wr(1, 16'hfffd);
    gap(1, n);
    gap(1, n);
    chk("baud gap", n, 6);
    chk("ovf", ovf, 1'b0);
    set_ctrl(6'h00);
  endtask : t_baud

  // Hang guard
  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0;
    ctrl = '0;
    cwr = '0;
    rwr = '0;
    oclr = 1'b0;
    eclr = 1'b0;
    preq = 1'b0;
    dir_up = 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    chk("rst count", cnt, 16'h0000);
    chk("rst flags", {ovf, ext, irq, poe}, 4'h0);
    t_timer_up();
    t_updown();
    t_counter();
    t_clock_out();
    t_baud();
    conclude();
  end
endmodule : tb
